/* hw/dbu_decrement_branch.sv */
// Decrement-and-branch execution unit of the core, standard and delayed forms.
// Assumes the core presents the instruction with its operands on issue and
// pulses slot_retire once per instruction retired in a delay slot.
//
// How it works
// - top six bits must be the branch opcode.
// - counter decremented on every execution.
// - branch only if condition true and counter nonnegative.
// - counter decrement works on 24 signed bits.
// - upper eight counter bits stay unchanged.
// - sign test looks at low 24 bits.
// - decrement never touches the tested flags.
// - flags come from last status-updating instruction.
// - mode bit picks register or PC-relative target.
// - register mode loads whole register, index to 27.
// - standard relative target is PC plus one plus offset.
// - offset is sign-extended low sixteen bits.
// - standard form takes four cycles.
// - twenty condition codes over the status flags.
// - flags updated only by R0-R7 writes or compares.
// - overflow saturate setting has no effect.
// - delayed relative target is PC plus three plus offset.
// - bit 21 set selects delayed form, three slots.
`timescale 1ns/1ps
`default_nettype none

module dbu_decrement_branch (
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic              clk_en,
   input  wire logic              issue,
   input  wire dbu_pkg::dbu_instr_t instr,
   input  wire logic [31:0]       inst_pc,
   input  wire logic [31:0]       aux_value,
   input  wire logic [31:0]       reg_value,
   input  wire logic              slot_retire,
   input  wire logic              flag_wr,
   input  wire logic [4:0]        flag_dest_idx,
   input  wire logic              flag_is_compare,
   input  wire dbu_pkg::dbu_flags_t flag_value,
   output logic                   aux_wr_en,
   output logic [2:0]             aux_wr_idx,
   output logic [31:0]            aux_wr_data,
   output logic                   pc_load,
   output logic [31:0]            pc_target,
   output logic                   busy,
   output logic                   done,
   output logic                   bad_instr,
   output dbu_pkg::dbu_flags_t    flags_out
);

   dbu_pkg::dbu_regs_t state_reg;
   dbu_pkg::dbu_regs_t state_next;

   logic        accept;
   logic        cond_ok;
   logic        cond_defined;
   logic        instr_ok;
   logic        take;
   logic [23:0] aux_dec;
   logic [31:0] target_calc;

   // Evaluates a condition code; unknown codes are reported as undefined.
   function automatic logic [1:0] cond_eval(input logic [4:0] code,
                                           input dbu_pkg::dbu_flags_t f);
      logic r;
      logic d;
      r = 1'b0;
      d = 1'b1;
      unique case (code)
         dbu_pkg::DBU_CC_U:    r = 1'b1;
         dbu_pkg::DBU_CC_LO:   r = f.c;
         dbu_pkg::DBU_CC_LS:   r = f.c | f.z;
         dbu_pkg::DBU_CC_HI:   r = ~f.c & ~f.z;
         dbu_pkg::DBU_CC_HS:   r = ~f.c;
         dbu_pkg::DBU_CC_EQ:   r = f.z;
         dbu_pkg::DBU_CC_NE:   r = ~f.z;
         dbu_pkg::DBU_CC_LT:   r = f.n;
         dbu_pkg::DBU_CC_LE:   r = f.n | f.z;
         dbu_pkg::DBU_CC_GT:   r = ~f.n & ~f.z;
         dbu_pkg::DBU_CC_GE:   r = ~f.n;
         dbu_pkg::DBU_CC_NV:   r = ~f.v;
         dbu_pkg::DBU_CC_V:    r = f.v;
         dbu_pkg::DBU_CC_NUF:  r = ~f.underflow_flag;
         dbu_pkg::DBU_CC_UF:   r = f.underflow_flag;
         dbu_pkg::DBU_CC_NLV:  r = ~f.latched_overflow_flag;
         dbu_pkg::DBU_CC_LV:   r = f.latched_overflow_flag;
         dbu_pkg::DBU_CC_NLUF: r = ~f.latched_underflow_flag;
         dbu_pkg::DBU_CC_LUF:  r = f.latched_underflow_flag;
         dbu_pkg::DBU_CC_ZUF:  r = f.z | f.underflow_flag;
         default:              d = 1'b0;
      endcase
      return {d, r};
   endfunction

   // Widens a 16-bit displacement to the 32-bit program counter width.
   function automatic logic [31:0] sext16(input logic [15:0] disp);
      return {{16{disp[15]}}, disp};
   endfunction

   always_comb begin
      accept = issue && (state_reg.st == dbu_pkg::DBU_IDLE);
      // The counter wraps within 24 bits; no saturation is applied, whatever the
      // overflow setting of the core says.
      aux_dec = aux_value[23:0] - 24'h000001;
      // Only the stored flags are consulted, never the decremented value.
      {cond_defined, cond_ok} = cond_eval(instr.cond, state_reg.flags);
      instr_ok = (instr.opcode == dbu_pkg::DBU_OPCODE) && cond_defined;
      if (!instr.pc_rel && (instr.field[4:0] > dbu_pkg::DBU_REG_MAX)) begin
         instr_ok = 1'b0;
      end
      take = cond_ok && !aux_dec[dbu_pkg::DBU_AUX_W-1];
      if (!instr.pc_rel) begin
         target_calc = reg_value;
      end else if (instr.delayed) begin
         target_calc = inst_pc + dbu_pkg::DBU_DLY_STEP
                       + sext16(instr.field);
      end else begin
         target_calc = inst_pc + dbu_pkg::DBU_STD_STEP
                       + sext16(instr.field);
      end
   end

   always_comb begin
      state_next = state_reg;
      state_next.aux_wr_en = 1'b0;
      state_next.pc_load   = 1'b0;
      state_next.done      = 1'b0;
      state_next.bad_instr = 1'b0;
      // Flags change only through the core's update port or reset, never through the decrement.
      if (flag_wr && ((flag_dest_idx <= dbu_pkg::DBU_EXT_REG_MAX) || flag_is_compare)) begin
         state_next.flags = flag_value;
      end
      unique case (state_reg.st)
         dbu_pkg::DBU_IDLE: begin
            // A refused word writes nothing back, so the counter survives a bad fetch.
            if (accept && !instr_ok) begin
               state_next.bad_instr = 1'b1;
               state_next.done      = 1'b1;
            end else if (accept) begin
               state_next.aux_wr_en   = 1'b1;
               state_next.aux_wr_idx  = instr.aux_sel;
               state_next.aux_wr_data = {aux_value[31:24], aux_dec};
               state_next.taken       = take;
               state_next.pc_target   = target_calc;
               state_next.cnt         = 3'h1;
               if (instr.delayed) begin
                  // Delayed form retires at once; the redirect waits for the slots.
                  state_next.done = 1'b1;
                  state_next.cnt  = 3'h0;
                  if (take) begin
                     state_next.st = dbu_pkg::DBU_SLOT;
                  end
               end else begin
                  state_next.busy = 1'b1;
                  state_next.st   = dbu_pkg::DBU_STD;
               end
            end
         end
         dbu_pkg::DBU_STD: begin
            // Occupancy is fixed so issue timing does not depend on the outcome.
            if (state_reg.cnt == dbu_pkg::DBU_STD_CYCLES - 3'h1) begin
               state_next.busy    = 1'b0;
               state_next.done    = 1'b1;
               state_next.pc_load = state_reg.taken;
               state_next.st      = dbu_pkg::DBU_IDLE;
            end else begin
               state_next.cnt = state_reg.cnt + 3'h1;
            end
         end
         dbu_pkg::DBU_SLOT: begin
            if (slot_retire) begin
               if (state_reg.cnt == dbu_pkg::DBU_DELAY_SLOTS - 3'h1) begin
                  state_next.pc_load = 1'b1;
                  state_next.cnt     = 3'h0;
                  state_next.st      = dbu_pkg::DBU_IDLE;
               end else begin
                  state_next.cnt = state_reg.cnt + 3'h1;
               end
            end
         end
         default: begin
            state_next.st = dbu_pkg::DBU_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_reg       <= '0;
         state_reg.st    <= dbu_pkg::DBU_IDLE;
         state_reg.flags <= dbu_pkg::DBU_FLAGS_RST;
      end else if (clk_en) begin
         state_reg <= state_next;
      end
   end

   assign aux_wr_en   = state_reg.aux_wr_en;
   assign aux_wr_idx  = state_reg.aux_wr_idx;
   assign aux_wr_data = state_reg.aux_wr_data;
   assign pc_load     = state_reg.pc_load;
   assign pc_target   = state_reg.pc_target;
   assign busy        = state_reg.busy;
   assign done        = state_reg.done;
   assign bad_instr   = state_reg.bad_instr;
   assign flags_out   = state_reg.flags;

   // Assertions count enabled edges only, since a low enable freezes all state.
   default clocking cb @(posedge clk iff clk_en);
   endclocking
   default disable iff (!resetn);

   sequence std_go_s;
      accept && instr_ok && !instr.delayed;
   endsequence

   sequence dly_go_s;
      accept && instr_ok && instr.delayed;
   endsequence

   sequence std_run_s;
      busy [*3] ##1 (done && !busy);
   endsequence

   // A taken delayed branch; the redirect must wait for three retired slots.
   sequence dly_take_s;
      dly_go_s ##0 take;
   endsequence

   sequence two_slots_s;
      slot_retire [*2];
   endsequence

   opcode_check_a: assert property (
      accept && (instr.opcode != dbu_pkg::DBU_OPCODE) |=> bad_instr && done && !aux_wr_en)
      else $error("wrong opcode was executed");

   aux_decrement_a: assert property (
      accept && instr_ok |=> aux_wr_en
         && (aux_wr_data[23:0] == $past(aux_value[23:0]) - 24'h000001))
      else $error("counter was not decremented");

   upper_keep_a: assert property (
      accept && instr_ok |=> aux_wr_data[31:24] == $past(aux_value[31:24]))
      else $error("upper counter bits changed");

   aux_select_a: assert property (
      accept && instr_ok |=> aux_wr_idx == $past(instr.aux_sel))
      else $error("wrong counter written");

   std_cycles_a: assert property (
      std_go_s |=> std_run_s)
      else $error("standard form did not take four cycles");

   std_taken_a: assert property (
      std_go_s and (take) |=> !pc_load [*3] ##1 pc_load)
      else $error("taken branch did not load the PC on time");

   std_fall_a: assert property (
      std_go_s and (!take) |=> !pc_load [*4])
      else $error("untaken branch loaded the PC");

   neg_count_a: assert property (
      accept && instr_ok && (aux_value[23:0] == 24'h000000) |=> !pc_load [*4])
      else $error("negative counter allowed a branch");

   rel_target_a: assert property (
      std_go_s and (instr.pc_rel) |=> pc_target
         == $past(inst_pc) + 32'h1 + {{16{$past(instr.field[15])}}, $past(instr.field)})
      else $error("relative target wrong");

   reg_target_a: assert property (
      accept && instr_ok && !instr.pc_rel |=> pc_target == $past(reg_value))
      else $error("register target wrong");

   dly_single_a: assert property (
      dly_go_s |=> done && !busy && !pc_load)
      else $error("delayed form not single cycle");

   dly_target_a: assert property (
      dly_go_s and (instr.pc_rel) |=> pc_target
         == $past(inst_pc) + 32'h3 + {{16{$past(instr.field[15])}}, $past(instr.field)})
      else $error("delayed relative target wrong");

   flag_hold_a: assert property (
      !flag_wr |=> $stable(flags_out))
      else $error("flags changed without an update");

   flag_filter_a: assert property (
      flag_wr && (flag_dest_idx > dbu_pkg::DBU_EXT_REG_MAX) && !flag_is_compare
         |=> $stable(flags_out))
      else $error("flags taken from a non-updating instruction");

   // Without this, a filter that dropped every update would still pass the hold checks.
   flag_take_a: assert property (
      flag_wr && ((flag_dest_idx <= dbu_pkg::DBU_EXT_REG_MAX) || flag_is_compare)
         |=> flags_out == $past(flag_value))
      else $error("status update was not taken");

   dly_early_a: assert property (
      dly_take_s ##1 two_slots_s |=> !pc_load)
      else $error("delayed redirect came before the third slot");

   dly_redirect_a: assert property (
      dly_take_s ##1 two_slots_s ##1 slot_retire |=> pc_load)
      else $error("delayed redirect missing after three slots");

   dly_fall_a: assert property (
      dly_go_s and (!take) |=> !pc_load [*2])
      else $error("untaken delayed branch loaded the PC");

   // A second request during a run is dropped, not queued; the core must hold it.
   refuse_busy_a: assert property (
      issue && busy |=> !aux_wr_en)
      else $error("request taken while a standard branch was running");

   done_once_a: assert property (
      std_go_s |=> !done [*3])
      else $error("standard form finished early");

   done_idle_a: assert property (
      done |-> !busy)
      else $error("done raised while still busy");

   bad_cond_a: assert property (
      accept && ((instr.cond == 5'h0b) || (instr.cond > dbu_pkg::DBU_CC_ZUF))
         |=> bad_instr && !aux_wr_en)
      else $error("undefined condition code was executed");

   reg_index_a: assert property (
      accept && !instr.pc_rel && (instr.field[4:0] > dbu_pkg::DBU_REG_MAX)
         |=> bad_instr && !aux_wr_en)
      else $error("register index above the top was accepted");

   eq_flags_a: assert property (
      accept && instr_ok && (instr.cond == dbu_pkg::DBU_CC_EQ) && !flags_out.z
         |=> !pc_load [*4])
      else $error("equal branch taken with zero flag clear");

   pc_pulse_a: assert property (
      pc_load |=> !pc_load)
      else $error("PC load held for more than one cycle");

endmodule

`default_nettype wire

/* hw/dbu_pkg.sv */
// Shared constants and types of the decrement-and-branch unit.
// Assumes one core clock and that the surrounding core supplies operands.
package dbu_pkg;

   // Instruction word layout, most significant field first.
   typedef struct packed {
      logic [5:0]  opcode;
      logic        pc_rel;
      logic [2:0]  aux_sel;
      logic        delayed;
      logic [4:0]  cond;
      logic [15:0] field;
   } dbu_instr_t;

   typedef struct packed {
      logic latched_underflow_flag;
      logic latched_overflow_flag;
      logic underflow_flag;
      logic n;
      logic z;
      logic v;
      logic c;
   } dbu_flags_t;

   typedef enum logic [1:0] {DBU_IDLE, DBU_STD, DBU_SLOT} dbu_state_t;

   typedef struct packed {
      dbu_state_t  st;
      logic [2:0]  cnt;
      logic        taken;
      dbu_flags_t  flags;
      logic        aux_wr_en;
      logic [2:0]  aux_wr_idx;
      logic [31:0] aux_wr_data;
      logic        pc_load;
      logic [31:0] pc_target;
      logic        busy;
      logic        done;
      logic        bad_instr;
   } dbu_regs_t;

   localparam logic [5:0]  DBU_OPCODE      = 6'h1b;
   localparam logic [4:0]  DBU_REG_MAX     = 5'h1b;
   localparam logic [4:0]  DBU_EXT_REG_MAX = 5'h07;
   localparam logic [2:0]  DBU_STD_CYCLES  = 3'h4;
   localparam logic [2:0]  DBU_DELAY_SLOTS = 3'h3;
   localparam logic [31:0] DBU_STD_STEP    = 32'h1;
   localparam logic [31:0] DBU_DLY_STEP    = 32'h3;
   localparam int          DBU_AUX_W       = 24;
   localparam dbu_flags_t  DBU_FLAGS_RST   = 7'h00;

   localparam logic [4:0] DBU_CC_U    = 5'h00;
   localparam logic [4:0] DBU_CC_LO   = 5'h01;
   localparam logic [4:0] DBU_CC_LS   = 5'h02;
   localparam logic [4:0] DBU_CC_HI   = 5'h03;
   localparam logic [4:0] DBU_CC_HS   = 5'h04;
   localparam logic [4:0] DBU_CC_EQ   = 5'h05;
   localparam logic [4:0] DBU_CC_NE   = 5'h06;
   localparam logic [4:0] DBU_CC_LT   = 5'h07;
   localparam logic [4:0] DBU_CC_LE   = 5'h08;
   localparam logic [4:0] DBU_CC_GT   = 5'h09;
   localparam logic [4:0] DBU_CC_GE   = 5'h0a;
   localparam logic [4:0] DBU_CC_NV   = 5'h0c;
   localparam logic [4:0] DBU_CC_V    = 5'h0d;
   localparam logic [4:0] DBU_CC_NUF  = 5'h0e;
   localparam logic [4:0] DBU_CC_UF   = 5'h0f;
   localparam logic [4:0] DBU_CC_NLV  = 5'h10;
   localparam logic [4:0] DBU_CC_LV   = 5'h11;
   localparam logic [4:0] DBU_CC_NLUF = 5'h12;
   localparam logic [4:0] DBU_CC_LUF  = 5'h13;
   localparam logic [4:0] DBU_CC_ZUF  = 5'h14;

endpackage

/* verif/test_decrement_and_branch_unit.sv */
// Self-checking bench for the decrement-and-branch unit, driven at its ports.
// Assumes the package is compiled first and the unit's assertions are inline.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
   $display("BAD %0t got %h exp %h", $time, got, exp); end end

module test_decrement_and_branch_unit;
   logic                clk;
   logic                resetn;
   logic                clk_en;
   logic                issue;
   dbu_pkg::dbu_instr_t instr;
   logic [31:0]         inst_pc;
   logic [31:0]         aux_value;
   logic [31:0]         reg_value;
   logic                slot_retire;
   logic                flag_wr;
   logic [4:0]          flag_dest_idx;
   logic                flag_is_compare;
   dbu_pkg::dbu_flags_t flag_value;
   logic                aux_wr_en;
   logic [2:0]          aux_wr_idx;
   logic [31:0]         aux_wr_data;
   logic                pc_load;
   logic [31:0]         pc_target;
   logic                busy;
   logic                done;
   logic                bad_instr;
   dbu_pkg::dbu_flags_t flags_out;
   dbu_pkg::dbu_flags_t exp_flags;
   int                  num_errors;
   int                  cmp_count;

   dbu_decrement_branch u_dbu_decrement_branch (
      .clk(clk), .resetn(resetn), .clk_en(clk_en), .issue(issue), .instr(instr),
      .inst_pc(inst_pc), .aux_value(aux_value), .reg_value(reg_value),
      .slot_retire(slot_retire), .flag_wr(flag_wr), .flag_dest_idx(flag_dest_idx),
      .flag_is_compare(flag_is_compare), .flag_value(flag_value), .aux_wr_en(aux_wr_en),
      .aux_wr_idx(aux_wr_idx), .aux_wr_data(aux_wr_data), .pc_load(pc_load),
      .pc_target(pc_target), .busy(busy), .done(done), .bad_instr(bad_instr),
      .flags_out(flags_out));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Expected condition outcome, worked out independently from the code table.
   function automatic logic cond_ok(input logic [4:0] cc, input dbu_pkg::dbu_flags_t f);
      case (cc)
         5'h00: return 1'b1;
         5'h01: return f.c;
         5'h02: return f.c | f.z;
         5'h03: return !f.c & !f.z;
         5'h04: return !f.c;
         5'h05: return f.z;
         5'h06: return !f.z;
         5'h07: return f.n;
         5'h08: return f.n | f.z;
         5'h09: return !f.n & !f.z;
         5'h0a: return !f.n;
         5'h0c: return !f.v;
         5'h0d: return f.v;
         5'h0e: return !f.underflow_flag;
         5'h0f: return f.underflow_flag;
         5'h10: return !f.latched_overflow_flag;
         5'h11: return f.latched_overflow_flag;
         5'h12: return !f.latched_underflow_flag;
         5'h13: return f.latched_underflow_flag;
         5'h14: return f.z | f.underflow_flag;
         default: return 1'b0;
      endcase
   endfunction

   function automatic dbu_pkg::dbu_instr_t mk(input logic rel, input logic [2:0] sel,
                                              input logic dly, input logic [4:0] cc,
                                              input logic [15:0] fld);
      return {dbu_pkg::DBU_OPCODE, rel, sel, dly, cc, fld};
   endfunction

   task automatic set_flag(input dbu_pkg::dbu_flags_t f, input logic [4:0] idx,
                           input logic cmp);
      @(posedge clk);
      #1;
      flag_wr = 1'b1;
      flag_value = f;
      flag_dest_idx = idx;
      flag_is_compare = cmp;
      @(posedge clk);
      #1;
      flag_wr = 1'b0;
      if (idx <= 5'h07 || cmp) exp_flags = f;
      `CHK(flags_out, exp_flags)
   endtask

   task automatic run(input dbu_pkg::dbu_instr_t i, input logic [31:0] pc, aux, regv);
      logic        bad;
      logic        tk;
      logic [23:0] dec;
      logic [31:0] tgt;
      int          n;
      bad = (i.opcode != dbu_pkg::DBU_OPCODE) || i.cond == 5'h0b || i.cond > 5'h14 ||
            (!i.pc_rel && i.field[4:0] > 5'd27);
      dec = aux[23:0] - 24'h1;
      tk = !bad && cond_ok(i.cond, exp_flags) && !dec[23];
      tgt = i.pc_rel ? pc + (i.delayed ? 32'h3 : 32'h1) + {{16{i.field[15]}}, i.field} : regv;
      @(posedge clk);
      #1;
      issue = 1'b1;
      instr = i;
      inst_pc = pc;
      aux_value = aux;
      reg_value = regv;
      @(posedge clk);
      #1;
      issue = 1'b0;
      `CHK(bad_instr, bad)
      `CHK(aux_wr_en, !bad)
      `CHK(busy, !bad && !i.delayed)
      if (!bad) begin
         `CHK(aux_wr_data, {aux[31:24], dec})
         `CHK(aux_wr_idx, i.aux_sel)
      end
      if (bad || i.delayed) begin
         `CHK(done, 1'b1)
      end else begin
         n = 0;
         while (done !== 1'b1 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
         end
         `CHK(n, 3)
         `CHK(busy, 1'b0)
      end
      if (i.delayed && tk) begin
         slot_retire = 1'b1;
         repeat (3) begin
            `CHK(pc_load, 1'b0)
            @(posedge clk);
            #1;
         end
         slot_retire = 1'b0;
      end
      `CHK(pc_load, tk)
      if (tk) `CHK(pc_target, tgt)
      `CHK(flags_out, exp_flags)
   endtask

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      #200000;
      num_errors++;
      end_sim();
   end

   initial begin
      dbu_pkg::dbu_flags_t fs[4];
      dbu_pkg::dbu_instr_t bi;
      fs = '{7'h00, 7'h7f, 7'h15, 7'h2a};
      num_errors = 0;
      cmp_count = 0;
      exp_flags = dbu_pkg::DBU_FLAGS_RST;
      resetn = 1'b0;
      clk_en = 1'b1;
      issue = 1'b0;
      instr = '0;
      inst_pc = 32'h0;
      aux_value = 32'h0;
      reg_value = 32'h0;
      slot_retire = 1'b0;
      flag_wr = 1'b0;
      flag_dest_idx = 5'h00;
      flag_is_compare = 1'b0;
      flag_value = 7'h00;
      repeat (10) @(posedge clk);
      #1;
      resetn = 1'b1;
      `CHK({busy, done, pc_load, aux_wr_en, flags_out}, 11'h000)
      // Every code against several flag patterns; undefined codes must be refused.
      for (int k = 0; k < 4; k++) begin
         set_flag(fs[k], 5'(k * 2), k[0]);
         for (int cc = 0; cc < 32; cc++)
            run(mk(1'b1, 3'(cc), 1'b0, 5'(cc), 16'h0010), 32'h100, 32'h5, 32'h0);
      end
      $display("test condition codes done");
      set_flag(7'h7f, 5'h09, 1'b0);
      set_flag(7'h04, 5'h14, 1'b1);
      set_flag(7'h7f, 5'h08, 1'b0);
      run(mk(1'b1, 3'h2, 1'b0, 5'h05, 16'h0004), 32'h40, 32'h9, 32'h0);
      run(mk(1'b1, 3'h2, 1'b0, 5'h06, 16'h0004), 32'h40, 32'h9, 32'h0);
      $display("test flag sources done");
      // Only the low 24 bits count; the top byte rides through untouched.
      run(mk(1'b1, 3'h7, 1'b0, 5'h00, 16'h0020), 32'h200, 32'hab000000, 32'h0);
      run(mk(1'b1, 3'h0, 1'b0, 5'h00, 16'h0020), 32'h200, 32'hff000001, 32'h0);
      run(mk(1'b1, 3'h1, 1'b0, 5'h00, 16'h0020), 32'h200, 32'h00800000, 32'h0);
      $display("test counter done");
      run(mk(1'b0, 3'h3, 1'b0, 5'h00, 16'hffdb), 32'h300, 32'h2, 32'h87654321);
      run(mk(1'b0, 3'h3, 1'b0, 5'h00, 16'h001c), 32'h300, 32'h2, 32'h87654321);
      run(mk(1'b1, 3'h4, 1'b0, 5'h00, 16'h8000), 32'h1000, 32'h2, 32'h0);
      run(mk(1'b1, 3'h4, 1'b0, 5'h00, 16'hfff0), 32'h1000, 32'h2, 32'h0);
      bi = mk(1'b1, 3'h4, 1'b0, 5'h00, 16'h0001);
      bi.opcode = 6'h1a;
      run(bi, 32'h1000, 32'h2, 32'h0);
      $display("test modes done");
      run(mk(1'b1, 3'h5, 1'b1, 5'h05, 16'h010d), 32'h100, 32'h67, 32'h0);
      run(mk(1'b0, 3'h6, 1'b1, 5'h00, 16'h0005), 32'h100, 32'h3, 32'h55aa0033);
      run(mk(1'b1, 3'h5, 1'b1, 5'h01, 16'h010d), 32'h100, 32'h67, 32'h0);
      run(mk(1'b1, 3'h5, 1'b1, 5'h00, 16'h010d), 32'h100, 32'h0, 32'h0);
      $display("test delayed form done");
      // A low enable freezes everything, pending requests and flag updates included.
      @(posedge clk);
      #1;
      clk_en = 1'b0;
      issue = 1'b1;
      instr = mk(1'b1, 3'h1, 1'b0, 5'h00, 16'h0001);
      flag_wr = 1'b1;
      flag_value = 7'h7f;
      flag_dest_idx = 5'h01;
      repeat (2) @(posedge clk);
      #1;
      `CHK({aux_wr_en, busy, done, flags_out}, {3'b000, exp_flags})
      issue = 1'b0;
      flag_wr = 1'b0;
      clk_en = 1'b1;
      // A request held through a standard run is taken once only.
      @(posedge clk);
      #1;
      issue = 1'b1;
      instr = mk(1'b1, 3'h2, 1'b0, 5'h00, 16'h0001);
      aux_value = 32'h10;
      @(posedge clk);
      #1;
      `CHK(aux_wr_en, 1'b1)
      repeat (3) begin
         @(posedge clk);
         #1;
         `CHK(aux_wr_en, 1'b0)
      end
      issue = 1'b0;
      `CHK(pc_load, 1'b1)
      // A reset after the run clears the held flags, so equal no longer branches.
      @(posedge clk);
      #1;
      resetn = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      resetn = 1'b1;
      exp_flags = dbu_pkg::DBU_FLAGS_RST;
      `CHK({busy, done, pc_load, aux_wr_en, flags_out}, 11'h000)
      run(mk(1'b1, 3'h2, 1'b0, 5'h05, 16'h0004), 32'h40, 32'h9, 32'h0);
      $display("test enable and reset done");
      end_sim();
   end
endmodule

`default_nettype wire
